//--- rxs_pkg.sv
// Package of constants and types for the reset and exception sequencer.
package rxs_pkg;

  // ****************************************************************
  // Timing counts in reference clock cycles
  // ****************************************************************
  localparam int RXS_CNT_W = 13;
  localparam logic [12:0] RXS_OSC_SETTLE = 13'h1000;
  localparam logic [12:0] RXS_PIN_HOLD = 13'h0020;
  localparam logic [12:0] RXS_RST_TAIL = 13'h0020;
  localparam logic [12:0] RXS_SHORT_REC = 13'h0020;

  // ****************************************************************
  // Reset cause register field positions
  // ****************************************************************
  localparam int RXS_CAUSE_POR = 7;
  localparam int RXS_CAUSE_PIN = 6;
  localparam int RXS_CAUSE_WDOG = 5;
  localparam int RXS_CAUSE_ILLEGAL_OPCODE_FLAG = 4;
  localparam int RXS_CAUSE_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int RXS_CAUSE_MON = 2;
  localparam int RXS_CAUSE_LV = 1;
  localparam logic [7:0] RXS_CAUSE_RST = 8'h80;

  // ****************************************************************
  // Register offsets of the plain register port
  // ****************************************************************
  localparam logic [3:0] RXS_REG_CAUSE = 4'h1;
  localparam logic [3:0] RXS_REG_INT1 = 4'h4;
  localparam logic [3:0] RXS_REG_INT2 = 4'h5;
  localparam logic [3:0] RXS_REG_INT3 = 4'h6;
  localparam logic [3:0] RXS_REG_CTRL = 4'h8;

  // Number of maskable interrupt sources.
  localparam int RXS_NIRQ = 16;

  // Vector select codes: 0 none, 1 reset, 2 software, 3+n maskable n.
  localparam logic [4:0] RXS_VEC_NONE = 5'h00;
  localparam logic [4:0] RXS_VEC_RESET = 5'h01;
  localparam logic [4:0] RXS_VEC_SWI = 5'h02;
  localparam logic [4:0] RXS_VEC_IRQ0 = 5'h03;

  // Sequencer states.
  typedef enum logic [2:0] {
    RXS_SETTLE,
    RXS_PIN_LOW,
    RXS_TAIL,
    RXS_RUN,
    RXS_STOP
  } rxs_state_t;

endpackage : rxs_pkg

//--- rxs_sequencer.sv
// Reset sequencer, stabilisation counter and exception arbiter.
// ****************************************************************
// Top module
// ****************************************************************
// Behaviour
// R1: Power-on holds pin low for 4096+32 cycles, releases core 32 cycles later.
// R2: Power-on asserts internal reset, enables clock output, gates core clocks.
// R3: Power-on sets power-on cause flag and clears all other cause flags.
// R4: Watchdog overflow resets and sets the watchdog cause flag.
// R5: Every internal reset source drives the reset pin low.
// R6: Watchdog disabled only by test voltage in monitor or break state.
// R7: Illegal opcode sets its flag and resets.
// R8: Stop with stop enable 0 counts as illegal opcode.
// R9: Only opcode fetch from unmapped address gives illegal address reset.
// R10: Low voltage sets flag, same long pin hold and tail as power-on.
// R11: Monitor-entry reset input causes an internal reset.
// R12: Stabilisation counter is 13 bits wide.
// R13: Stop clears counter; wake delay is 32 if short recovery, else 4096.
// R14: External pin reset leaves counter alone; counter free-runs afterwards.
// R15: Latched interrupt holds vector until serviced or mask cleared.
// R16: Interrupt taken only at instruction end, mask clear, source enabled.
// R17: Highest priority pending served first; reset, software, then flag 1.
// R18: Entry saves registers and sets mask; return restores them.
// R19: Entry does not push the high index register.
// R20: Software interrupt ignores mask and pushes PC; hardware pushes PC-1.
// R21: Sixteen status flags, flag 1 highest to flag 16 lowest.
// R22: Internal reset drives pin 32 cycles, then internal reset 32 more.
module rxs_sequencer
  import rxs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic osc_ref_tick,
  input wire logic power_on_pulse,
  input wire logic watchdog_overflow,
  input wire logic illegal_instr,
  input wire logic stop_instr,
  input wire logic stop_enable,
  input wire logic short_stop_recovery,
  input wire logic opcode_fetch,
  input wire logic unmapped_access,
  input wire logic low_voltage_flag,
  input wire logic monitor_entry_reset,
  input wire logic monitor_mode,
  input wire logic break_state,
  input wire logic test_high_voltage_rst,
  input wire logic test_high_voltage_irq,
  input wire logic reset_pin_in,
  input wire logic wake_event,
  input wire logic instr_done,
  input wire logic mask_bit,
  input wire logic swi_instr,
  input wire logic int_serviced,
  input wire logic [15:0] irq_req,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic internal_reset,
  output logic clock_gen_output,
  output logic core_clk_en,
  output logic watchdog_disable,
  output logic int_take,
  output logic [4:0] int_vector,
  output logic push_pc_minus_one,
  output logic push_high_index,
  output logic set_mask
);

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************
  logic [2:0] pin_sync_q;
  logic pin_low_q;

  // Three stages; a change counts once stages two and three agree.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pin_sync_q <= 3'h7;
      pin_low_q <= 1'b0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[1:0], reset_pin_in};
      if (pin_sync_q[1] == pin_sync_q[2])
      begin
        pin_low_q <= ~pin_sync_q[2];
      end
    end
  end

  // ****************************************************************
  // Reset sources and sequencer
  // ****************************************************************
  logic illegal_opcode_flag_ev;
  logic illegal_address_flag_ev;
  logic long_ev;
  logic int_rst_ev;
  rxs_state_t state_q;
  logic [RXS_CNT_W-1:0] cnt_q;
  logic [RXS_CNT_W-1:0] target_q;
  logic [7:0] cause_q;
  logic [15:0] enable_q;

  // Stop with stop disabled is an illegal opcode; only fetches fault.
  assign illegal_opcode_flag_ev = illegal_instr | (stop_instr & ~stop_enable); // R7 R8
  assign illegal_address_flag_ev = opcode_fetch & unmapped_access; // R9
  assign long_ev = power_on_pulse | low_voltage_flag; // R10
  assign int_rst_ev = illegal_opcode_flag_ev | illegal_address_flag_ev | watchdog_overflow | monitor_entry_reset; // R4 R11

  // State sequencing by reference ticks; in stop the counter waits for a wake.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q <= RXS_SETTLE;
      cnt_q <= '0;
      target_q <= RXS_OSC_SETTLE + RXS_PIN_HOLD;
    end
    else if (long_ev)
    begin
      state_q <= RXS_PIN_LOW; // R1 R2
      cnt_q <= '0;
      target_q <= RXS_OSC_SETTLE + RXS_PIN_HOLD; // R10
    end
    else if (int_rst_ev)
    begin
      state_q <= RXS_PIN_LOW; // R22
      cnt_q <= '0;
      target_q <= RXS_PIN_HOLD;
    end
    else if (state_q == RXS_RUN && stop_instr && stop_enable)
    begin
      state_q <= RXS_STOP;
      cnt_q <= '0; // R13
      target_q <= short_stop_recovery ? RXS_SHORT_REC : RXS_OSC_SETTLE; // R13
    end
    else if (osc_ref_tick)
    begin
      cnt_q <= cnt_q + 13'(state_q != RXS_STOP || wake_event); // R12 R13 R14
      case (state_q)
        RXS_SETTLE, RXS_PIN_LOW:
        begin
          if (cnt_q == target_q - 13'h0001)
          begin
            state_q <= RXS_TAIL;
            cnt_q <= '0;
          end
        end
        RXS_TAIL:
        begin
          if (cnt_q == RXS_RST_TAIL - 13'h0001)
          begin
            state_q <= RXS_RUN; // R1 R22
          end
        end
        RXS_STOP:
        begin
          if (wake_event && cnt_q >= target_q - 13'h0001)
          begin
            state_q <= RXS_RUN; // R13
          end
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Reset cause register; power-on clears all others.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cause_q <= RXS_CAUSE_RST;
    end
    else if (power_on_pulse)
    begin
      cause_q <= RXS_CAUSE_RST; // R3
    end
    else
    begin
      if (watchdog_overflow) cause_q[RXS_CAUSE_WDOG] <= 1'b1; // R4
      if (illegal_opcode_flag_ev) cause_q[RXS_CAUSE_ILLEGAL_OPCODE_FLAG] <= 1'b1; // R7
      if (illegal_address_flag_ev) cause_q[RXS_CAUSE_ILLEGAL_ADDRESS_FLAG] <= 1'b1; // R9
      if (low_voltage_flag) cause_q[RXS_CAUSE_LV] <= 1'b1; // R10
      if (monitor_entry_reset) cause_q[RXS_CAUSE_MON] <= 1'b1; // R11
      if (pin_low_q && state_q == RXS_RUN) cause_q[RXS_CAUSE_PIN] <= 1'b1;
    end
  end

  // Pin drive, internal reset and clock gating from the state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      internal_reset <= 1'b1;
      clock_gen_output <= 1'b1;
      core_clk_en <= 1'b0;
    end
    else
    begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= ~(state_q == RXS_PIN_LOW || state_q == RXS_SETTLE); // R5
      internal_reset <= (state_q != RXS_RUN && state_q != RXS_STOP) || pin_low_q; // R2
      clock_gen_output <= 1'b1; // R2
      core_clk_en <= (state_q == RXS_RUN); // R2 R13
    end
  end

  // Watchdog disable purely from qualified test voltage.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      watchdog_disable <= 1'b0;
    end
    else
    begin
      watchdog_disable <= (monitor_mode & (test_high_voltage_rst | test_high_voltage_irq))
                          | (break_state & test_high_voltage_rst); // R6
    end
  end

  // ****************************************************************
  // Interrupt latch and arbitration
  // ****************************************************************
  logic [15:0] pend_q;
  logic latched_q;
  logic [4:0] win_vec;

  // Sticky flags; a new request wins over a service clear.
  always_ff @(posedge clk_sys)
  begin
    if (srst || internal_reset)
    begin
      pend_q <= '0;
    end
    else
    begin
      for (int i = 0; i < RXS_NIRQ; i++)
      begin
        if (irq_req[i]) pend_q[i] <= 1'b1; // R21
        else if (int_take && !push_pc_minus_one == 1'b0 && int_vector == RXS_VEC_IRQ0 + 5'(i))
          pend_q[i] <= 1'b0;
      end
    end
  end

  // Lowest index enabled pending flag has the highest priority.
  always_comb
  begin
    win_vec = RXS_VEC_NONE;
    for (int i = RXS_NIRQ - 1; i >= 0; i--)
    begin
      if (pend_q[i] && enable_q[i]) win_vec = RXS_VEC_IRQ0 + 5'(i); // R17
    end
  end

  // Latch vector at instruction end; hold until service or mask clear.
  always_ff @(posedge clk_sys)
  begin
    if (srst || internal_reset)
    begin
      latched_q <= 1'b0;
      int_take <= 1'b0;
      int_vector <= RXS_VEC_RESET; // R17
      push_pc_minus_one <= 1'b0;
      push_high_index <= 1'b0;
      set_mask <= 1'b0;
    end
    else
    begin
      int_take <= 1'b0;
      set_mask <= 1'b0;
      push_high_index <= 1'b0; // R19
      if (latched_q)
      begin
        if (int_serviced || !mask_bit) latched_q <= 1'b0; // R15
      end
      else if (instr_done && swi_instr)
      begin
        latched_q <= 1'b1;
        int_take <= 1'b1;
        int_vector <= RXS_VEC_SWI; // R20
        push_pc_minus_one <= 1'b0; // R20
        set_mask <= 1'b1; // R18
      end
      else if (instr_done && !mask_bit && win_vec != RXS_VEC_NONE)
      begin
        latched_q <= 1'b1; // R15 R16
        int_take <= 1'b1;
        int_vector <= win_vec;
        push_pc_minus_one <= 1'b1; // R20
        set_mask <= 1'b1; // R18
      end
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      enable_q <= '0;
      reg_rdata <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == RXS_REG_CTRL) enable_q[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == RXS_REG_CTRL + 4'h1) enable_q[15:8] <= reg_wdata;
      reg_rdata <= '0;
      if (reg_rd)
      begin
        case (reg_addr)
          RXS_REG_CAUSE: reg_rdata <= cause_q;
          RXS_REG_INT1: reg_rdata <= {pend_q[5:0], 2'b00};
          RXS_REG_INT2: reg_rdata <= pend_q[13:6];
          RXS_REG_INT3: reg_rdata <= {6'h00, pend_q[15:14]};
          RXS_REG_CTRL: reg_rdata <= enable_q[7:0];
          RXS_REG_CTRL + 4'h1: reg_rdata <= enable_q[15:8];
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_por_flag;
    @(posedge clk_sys) disable iff (srst) power_on_pulse |=> cause_q == RXS_CAUSE_RST;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("por cause wrong"); // R3

  property p_wdog_flag;
    @(posedge clk_sys) disable iff (srst)
      watchdog_overflow && !power_on_pulse |=> cause_q[RXS_CAUSE_WDOG];
  endproperty
  a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog flag"); // R4

  property p_pin_drive;
    @(posedge clk_sys) disable iff (srst) int_rst_ev |=> ##1 !reset_pin_oe_n;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven"); // R5

  property p_wdog_dis;
    @(posedge clk_sys) disable iff (srst)
      watchdog_disable |-> $past(test_high_voltage_rst | test_high_voltage_irq);
  endproperty
  a_wdog_dis: assert property (p_wdog_dis) else $error("watchdog disabled"); // R6

  property p_illegal_address_flag_data;
    @(posedge clk_sys) disable iff (srst)
      unmapped_access && !opcode_fetch && !cause_q[RXS_CAUSE_ILLEGAL_ADDRESS_FLAG] && !power_on_pulse
      |=> !cause_q[RXS_CAUSE_ILLEGAL_ADDRESS_FLAG];
  endproperty
  a_illegal_address_flag_data: assert property (p_illegal_address_flag_data) else $error("data access fault"); // R9

  property p_hold;
    @(posedge clk_sys) disable iff (srst || internal_reset)
      latched_q && mask_bit && !int_serviced |=> $stable(int_vector);
  endproperty
  a_hold: assert property (p_hold) else $error("latched vector moved"); // R15

  property p_take_mask;
    @(posedge clk_sys) disable iff (srst || internal_reset)
      int_take && push_pc_minus_one |-> $past(!mask_bit && instr_done);
  endproperty
  a_take_mask: assert property (p_take_mask) else $error("masked take"); // R16

  property p_entry;
    @(posedge clk_sys) disable iff (srst) int_take |-> set_mask && !push_high_index;
  endproperty
  a_entry: assert property (p_entry) else $error("entry outputs"); // R18

  property p_swi;
    @(posedge clk_sys) disable iff (srst)
      int_take && int_vector == RXS_VEC_SWI |-> !push_pc_minus_one;
  endproperty
  a_swi: assert property (p_swi) else $error("swi push"); // R20

  c_swi: cover property (@(posedge clk_sys) int_take && int_vector == RXS_VEC_SWI);
  c_irq: cover property (@(posedge clk_sys) int_take && push_pc_minus_one);
  c_run: cover property (@(posedge clk_sys) core_clk_en);
  c_stop: cover property (@(posedge clk_sys) state_q == RXS_STOP);

endmodule : rxs_sequencer

//--- rxs_partner.sv
// Far-side model: reference tick, open-drain reset pin and servicing core.
module rxs_partner (
  input wire logic clk_sys,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic ext_low,
  input wire logic int_take,
  input wire logic svc_en,
  output logic osc_ref_tick,
  output logic reset_pin_in,
  output logic int_serviced
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_q = 1'b0;

  // Reference tick every second cycle, so that ticks and cycles differ.
  initial osc_ref_tick = 1'b0;
  always @(posedge clk_sys) osc_ref_tick <= ~osc_ref_tick;

  // The pin has a pull-up; any party driving low wins.
  assign reset_pin_in = (reset_pin_oe_n ? 1'b1 : reset_pin_out) & ~ext_low;

  // The core finishes its handler two cycles after entry, unless told to stall.
  initial int_serviced = 1'b0;
  always @(posedge clk_sys)
  begin
    busy_q <= (busy_q | int_take) & ~int_serviced;
    int_serviced <= busy_q & svc_en & ~int_serviced;
  end
endmodule : rxs_partner

//--- rxs_sequencer_bench.sv
// Self-checking bench of the reset and exception sequencer.
module rxs_sequencer_bench
  import rxs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, srst = 1'b1, power_on_pulse = 1'b0, watchdog_overflow = 1'b0;
  logic illegal_instr = 1'b0, stop_instr = 1'b0, stop_enable = 1'b0, short_stop_recovery = 1'b0;
  logic opcode_fetch = 1'b0, unmapped_access = 1'b0, low_voltage_flag = 1'b0;
  logic monitor_entry_reset = 1'b0, monitor_mode = 1'b0, break_state = 1'b0;
  logic test_high_voltage_rst = 1'b0, test_high_voltage_irq = 1'b0, wake_event = 1'b0;
  logic instr_done = 1'b0, mask_bit = 1'b0, swi_instr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] irq_req = 16'h0000;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, rd;
  logic [4:0] int_vector;
  logic reset_pin_in, reset_pin_out, reset_pin_oe_n, internal_reset, clock_gen_output;
  logic core_clk_en, watchdog_disable, int_take, push_pc_minus_one, push_high_index;
  logic set_mask, osc_ref_tick, int_serviced, ext_low = 1'b0, svc_en = 1'b1;
  logic [31:0] seed = 32'h00016F5E;
  logic [3:0] a, b;
  logic [11:0] loc;
  int mismatches = 0, n_checks = 0, k, p, n;
  int cb [7] = '{RXS_CAUSE_POR, RXS_CAUSE_WDOG, RXS_CAUSE_ILLEGAL_OPCODE_FLAG, RXS_CAUSE_ILLEGAL_OPCODE_FLAG,
                 RXS_CAUSE_ILLEGAL_ADDRESS_FLAG, RXS_CAUSE_MON, RXS_CAUSE_LV};

  // Device and far side.
  rxs_sequencer rxs_sequencer_i (.clk_sys, .srst, .osc_ref_tick, .power_on_pulse,
    .watchdog_overflow, .illegal_instr, .stop_instr, .stop_enable, .short_stop_recovery,
    .opcode_fetch, .unmapped_access, .low_voltage_flag, .monitor_entry_reset, .monitor_mode,
    .break_state, .test_high_voltage_rst, .test_high_voltage_irq, .reset_pin_in, .wake_event,
    .instr_done, .mask_bit, .swi_instr, .int_serviced, .irq_req, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reset_pin_out, .reset_pin_oe_n, .internal_reset,
    .clock_gen_output, .core_clk_en, .watchdog_disable, .int_take, .int_vector,
    .push_pc_minus_one, .push_high_index, .set_mask);
  rxs_partner rxs_partner_i (.clk_sys, .reset_pin_out, .reset_pin_oe_n, .ext_low,
    .int_take, .svc_en, .osc_ref_tick, .reset_pin_in, .int_serviced);

  // The system clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Register and bit mask of status flag k+1.
  function automatic logic [11:0] flag_loc(input logic [3:0] k);
    if (k < 6)
      return {RXS_REG_INT1, 8'h04 << k};
    if (k < 14)
      return {RXS_REG_INT2, 8'h01 << (k - 6)};
    return {RXS_REG_INT3, 8'h01 << (k - 14)};
  endfunction : flag_loc

  // Watchdog disable from monitor, break, rst voltage and irq voltage.
  function automatic logic wd_exp(input logic [3:0] v);
    return (v[3] & (v[1] | v[0])) | (v[2] & v[1]);
  endfunction : wd_exp

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] ad);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr

  // Counts reference ticks while the pin is low, then while reset stays on.
  task automatic measure(input int exp_pin);
    int t;
    logic ce;
    p = 0;
    t = 0;
    n = 0;
    ce = 1'b0;
    while (reset_pin_oe_n !== 1'b0 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    while (reset_pin_oe_n === 1'b0 && n < 20000)
    begin
      @(posedge clk_sys);
      p += int'(osc_ref_tick);
      ce |= core_clk_en | ~clock_gen_output;
      n++;
    end
    while (internal_reset === 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      t += int'(osc_ref_tick);
      n++;
    end
    if (n >= 20000)
      mismatches++;
    if (n >= 20000)
      stop_test();
    check(16'(p >= exp_pin - 1 && p <= exp_pin + 2), 16'h0001);
    check(16'(t >= 31 && t <= 34), 16'h0001);
    check(16'(ce), 16'h0000);
  endtask : measure

  task automatic raise(input logic [15:0] bits);
    @(posedge clk_sys);
    irq_req <= bits;
    @(posedge clk_sys);
    irq_req <= 16'h0000;
  endtask : raise

  // One instruction boundary; v is the vector expected, or none.
  task automatic take(input logic m, input logic s, input logic [4:0] v);
    @(posedge clk_sys);
    instr_done <= 1'b1;
    mask_bit <= m;
    swi_instr <= s;
    @(posedge clk_sys);
    instr_done <= 1'b0;
    swi_instr <= 1'b0;
    // The core sets its mask once the boundary is over, as on a real entry.
    mask_bit <= 1'b1;
    #1;
    check(16'(int_take), 16'(v != RXS_VEC_NONE));
    if (v != RXS_VEC_NONE)
      check(16'(int_vector), 16'(v));
    if (v != RXS_VEC_NONE)
      check(16'({push_pc_minus_one, set_mask, push_high_index}), 16'({~s, 2'b10}));
    repeat (4) @(posedge clk_sys);
  endtask : take

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    measure(4128);
    rdr(RXS_REG_CAUSE);
    check(16'(rd), 16'(RXS_CAUSE_RST));
    rdr(4'hF);
    check(16'(rd), 16'h0000);
    wr(RXS_REG_CTRL, 8'hFF);
    wr(RXS_REG_CTRL + 4'h1, 8'hFF);
    // Two random requests: flag visible, masked, then served by priority.
    for (k = 0; k < 6; k++)
    begin
      seed = xs(seed);
      a = seed[3:0];
      b = seed[7:4];
      raise((16'h0001 << a) | (16'h0001 << b));
      loc = flag_loc(a);
      rdr(loc[11:8]);
      check(16'(rd & loc[7:0]), 16'(loc[7:0]));
      take(1'b1, 1'b0, RXS_VEC_NONE);
      take(1'b0, 1'b0, RXS_VEC_IRQ0 + 5'(a < b ? a : b));
      if (a != b)
        take(1'b0, 1'b0, RXS_VEC_IRQ0 + 5'(a < b ? b : a));
    end
    // A latched lowest request keeps its vector against a higher one.
    svc_en <= 1'b0;
    raise(16'h8000);
    take(1'b0, 1'b0, RXS_VEC_IRQ0 + 5'h0F);
    @(posedge clk_sys);
    mask_bit <= 1'b1;
    raise(16'h0001);
    repeat (3) @(posedge clk_sys);
    check(16'(int_vector), 16'(RXS_VEC_IRQ0 + 5'h0F));
    take(1'b1, 1'b1, RXS_VEC_NONE);
    svc_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    take(1'b1, 1'b1, RXS_VEC_SWI);
    take(1'b0, 1'b0, RXS_VEC_IRQ0);
    // Watchdog disable under random test voltages and modes.
    for (k = 0; k < 10; k++)
    begin
      seed = xs(seed);
      @(posedge clk_sys);
      {monitor_mode, break_state, test_high_voltage_rst, test_high_voltage_irq} <= seed[3:0];
      repeat (4) @(posedge clk_sys);
      check(16'(watchdog_disable), 16'(wd_exp(seed[3:0])));
    end
    @(posedge clk_sys);
    {monitor_mode, break_state, test_high_voltage_rst, test_high_voltage_irq} <= 4'h0;
    // Every internal reset source, each after a harmless data access to unmapped space.
    for (k = 0; k < 7; k++)
    begin
      @(posedge clk_sys);
      unmapped_access <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(16'(internal_reset), 16'h0000);
      power_on_pulse <= (k == 0);
      watchdog_overflow <= (k == 1);
      illegal_instr <= (k == 2);
      stop_instr <= (k == 3);
      opcode_fetch <= (k == 4);
      unmapped_access <= (k == 4);
      monitor_entry_reset <= (k == 5);
      low_voltage_flag <= (k == 6);
      @(posedge clk_sys);
      {power_on_pulse, watchdog_overflow, illegal_instr, stop_instr} <= 4'h0;
      {opcode_fetch, unmapped_access, monitor_entry_reset, low_voltage_flag} <= 4'h0;
      measure((k == 0 || k == 6) ? 4128 : 32);
      rdr(RXS_REG_CAUSE);
      check(16'(rd[cb[k]]), 16'h0001);
    end
    // Stop recovery, short and long.
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk_sys);
      stop_enable <= 1'b1;
      short_stop_recovery <= (k == 0);
      stop_instr <= 1'b1;
      @(posedge clk_sys);
      stop_instr <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check(16'(core_clk_en), 16'h0000);
      wake_event <= 1'b1;
      p = 0;
      n = 0;
      while (core_clk_en !== 1'b1 && n < 20000)
      begin
        @(posedge clk_sys);
        p += int'(osc_ref_tick);
        n++;
      end
      if (n >= 20000)
      begin
        mismatches++;
        stop_test();
      end
      wake_event <= 1'b0;
      check(16'(p >= (k == 0 ? 31 : 4095) && p <= (k == 0 ? 34 : 4098)), 16'h0001);
    end
    // An external pin reset holds the core briefly, leaves the sequencer, sets the pin flag.
    @(posedge clk_sys);
    ext_low <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(16'(internal_reset), 16'h0001);
    ext_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(16'({internal_reset, reset_pin_oe_n}), 16'h0001);
    rdr(RXS_REG_CAUSE);
    check(16'(rd[RXS_CAUSE_PIN]), 16'h0001);
    stop_test();
  end
endmodule : rxs_sequencer_bench
